// file: src/opdec_top.sv
// decoder and execution timer for one slice of a 16-bit instruction set
// assumes opcode bytes arrive from fetch logic on CLK_SYS with a valid/ready handshake
`include "opdec_regs.svh"
module opdec_top (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // opcode byte stream
  input wire logic BYTE_VALID,
  input wire logic [7:0] BYTE_DATA,
  output logic BYTE_READY,
  // mode: 1 protected, 0 real
  input wire logic PROT_MODE,
  // decode result
  output logic DEC_VALID,
  output opdec_pkg::op_t DEC_OP,
  output logic [2:0] DEC_REG,
  output logic [2:0] DEC_RM,
  output logic [1:0] DEC_MOD,
  output logic DEC_WORD,
  output logic DEC_TO_REG,
  output logic DEC_IMM,
  output logic DEC_ILLEGAL,
  output logic [4:0] DEC_CLOCKS,
  // end of execution
  output logic EXEC_DONE
);
  opdec_pkg::state_t state_q, state_d;
  opdec_pkg::op_t op_q, op_d;
  logic [7:0] opc_q;
  logic [2:0] reg_q, rm_q;
  logic [1:0] mod_q;
  logic word_q, dir_q, imm_q, ill_q, valid_q;
  logic [4:0] clk_q;
  logic load_t;
  logic timer_done;

  wire logic take = BYTE_VALID && BYTE_READY;
  wire logic [7:0] b = BYTE_DATA;
  // first-byte decode
  wire logic is_eol = (b == `OPC_EOL);
  wire logic is_fds = (b == `OPC_FPL_DS);
  wire logic is_fes = (b == `OPC_FPL_ES);
  wire logic is_f2a = (b == `OPC_F2A);
  wire logic is_a2f = (b == `OPC_A2F);
  wire logic is_fsv = (b == `OPC_FSAVE);
  wire logic is_frs = (b == `OPC_FREST);
  wire logic is_add_rm = (b[7:2] == `OPC_ADD_RM);
  wire logic is_adc_rm = (b[7:2] == `OPC_ADC_RM);
  wire logic is_sub_rm = (b[7:2] == `OPC_SUB_RM);
  wire logic is_imm = (b[7:2] == `OPC_IMM_GRP);
  wire logic is_add_acc = (b[7:1] == `OPC_ADD_ACC);
  wire logic is_adc_acc = (b[7:1] == `OPC_ADC_ACC);
  wire logic is_inc_rm = (b[7:1] == `OPC_INCDEC_RM);
  wire logic is_inc_reg = (b[7:3] == `OPC_INC_REG);
  wire logic one_byte = is_f2a | is_a2f | is_fsv | is_frs | is_inc_reg
                      | is_add_acc | is_adc_acc;
  wire logic needs_modrm = is_eol | is_fds | is_fes | is_add_rm | is_adc_rm
                         | is_sub_rm | is_imm | is_inc_rm;
  // second-byte fields
  wire logic [1:0] m_mod = b[7:6];
  wire logic [2:0] m_reg = b[5:3];
  wire logic [2:0] m_rm = b[2:0];
  wire logic m_regform = (m_mod == `MOD_REG);

  // timing selection for the instruction being completed
  logic [4:0] clocks_sel;
  logic ill_sel;
  opdec_pkg::op_t op2_sel;
  always_comb
  begin
    clocks_sel = `CLK_ALU_REG;
    ill_sel = 1'b0;
    op2_sel = op_q;
    case (op_q)
      opdec_pkg::OP_EOL: clocks_sel = `CLK_EOL;
      opdec_pkg::OP_FPL_DS:
      begin
        clocks_sel = PROT_MODE ? `CLK_FPL_PROT : `CLK_FPL_REAL;
        ill_sel = m_regform;
      end
      opdec_pkg::OP_FPL_ES:
      begin
        clocks_sel = PROT_MODE ? `CLK_FPL_PROT : `CLK_FPL_REAL;
        ill_sel = m_regform;
      end
      opdec_pkg::OP_SUB, opdec_pkg::OP_ADD, opdec_pkg::OP_ADC:
      begin
        if (imm_q)
        begin
          clocks_sel = m_regform ? `CLK_IMM_REG : `CLK_ALU_MEM;
          if (m_reg == `SUB_ADD)
            op2_sel = opdec_pkg::OP_ADD;
          else if (m_reg == `SUB_ADC)
            op2_sel = opdec_pkg::OP_ADC;
          else
            ill_sel = 1'b1;
        end
        else
          clocks_sel = m_regform ? `CLK_ALU_REG : `CLK_ALU_MEM;
      end
      opdec_pkg::OP_INC:
      begin
        clocks_sel = m_regform ? `CLK_ALU_REG : `CLK_ALU_MEM;
        ill_sel = (m_reg != `SUB_INC);
      end
      default: clocks_sel = `CLK_ALU_REG;
    endcase
  end

  // first-byte class and one-byte clock counts
  logic [4:0] clocks_one;
  always_comb
  begin
    op_d = opdec_pkg::OP_NONE;
    clocks_one = `CLK_FLAGXFER;
    if (is_eol) op_d = opdec_pkg::OP_EOL;
    else if (is_fds) op_d = opdec_pkg::OP_FPL_DS;
    else if (is_fes) op_d = opdec_pkg::OP_FPL_ES;
    else if (is_f2a) op_d = opdec_pkg::OP_F2A;
    else if (is_a2f) op_d = opdec_pkg::OP_A2F;
    else if (is_fsv)
    begin
      op_d = opdec_pkg::OP_FSAVE;
      clocks_one = `CLK_FSAVE;
    end
    else if (is_frs)
    begin
      op_d = opdec_pkg::OP_FREST;
      clocks_one = `CLK_FREST;
    end
    else if (is_add_rm | is_add_acc) op_d = opdec_pkg::OP_ADD;
    else if (is_adc_rm | is_adc_acc) op_d = opdec_pkg::OP_ADC;
    else if (is_sub_rm | is_imm) op_d = opdec_pkg::OP_SUB;
    else if (is_inc_rm | is_inc_reg) op_d = opdec_pkg::OP_INC;
    if (is_add_acc | is_adc_acc)
      clocks_one = `CLK_ACC_IMM;
    else if (is_inc_reg)
      clocks_one = `CLK_INC_REG;
  end

  // state sequencing
  always_comb
  begin
    state_d = state_q;
    load_t = 1'b0;
    case (state_q)
      opdec_pkg::ST_IDLE:
        if (take)
        begin
          if (needs_modrm)
            state_d = opdec_pkg::ST_MODRM;
          else
          begin
            state_d = opdec_pkg::ST_EXEC;
            load_t = 1'b1;
          end
        end
      opdec_pkg::ST_MODRM:
        if (take)
        begin
          state_d = opdec_pkg::ST_EXEC;
          load_t = 1'b1;
        end
      opdec_pkg::ST_EXEC:
        if (timer_done)
          state_d = opdec_pkg::ST_IDLE;
      default: state_d = opdec_pkg::ST_IDLE;
    endcase
  end

  assign BYTE_READY = (state_q != opdec_pkg::ST_EXEC);
  wire logic first_take = take && (state_q == opdec_pkg::ST_IDLE);
  wire logic second_take = take && (state_q == opdec_pkg::ST_MODRM);
  wire logic [4:0] clocks_load = second_take ? clocks_sel : clocks_one;

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_q <= opdec_pkg::ST_IDLE;
      op_q <= opdec_pkg::OP_NONE;
      opc_q <= 8'h00;
      reg_q <= 3'h0;
      rm_q <= 3'h0;
      mod_q <= 2'h0;
      word_q <= 1'b0;
      dir_q <= 1'b0;
      imm_q <= 1'b0;
      ill_q <= 1'b0;
      valid_q <= 1'b0;
      clk_q <= 5'h00;
    end
    else
    begin
      state_q <= state_d;
      valid_q <= load_t;
      if (first_take)
      begin
        opc_q <= b;
        op_q <= op_d;
        word_q <= b[0];
        dir_q <= b[1] & (is_add_rm | is_adc_rm | is_sub_rm);
        imm_q <= is_imm | is_add_acc | is_adc_acc;
        reg_q <= is_inc_reg ? b[2:0] : 3'h0;
        rm_q <= 3'h0;
        mod_q <= 2'h0;
        ill_q <= (op_d == opdec_pkg::OP_NONE);
        if (!needs_modrm)
          clk_q <= clocks_load;
      end
      if (second_take)
      begin
        op_q <= op2_sel;
        mod_q <= m_mod;
        reg_q <= m_reg;
        rm_q <= m_rm;
        ill_q <= ill_sel;
        clk_q <= clocks_load;
      end
    end
  end

  cycle_timer #(.W(5)) u_timer (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .load(load_t),
    .count(clocks_load),
    .done(timer_done)
  );

  assign DEC_VALID = valid_q;
  assign DEC_OP = op_q;
  assign DEC_REG = reg_q;
  assign DEC_RM = rm_q;
  assign DEC_MOD = mod_q;
  assign DEC_WORD = word_q;
  assign DEC_TO_REG = dir_q;
  assign DEC_IMM = imm_q;
  assign DEC_ILLEGAL = ill_q;
  assign DEC_CLOCKS = clk_q;
  assign EXEC_DONE = timer_done && (state_q == opdec_pkg::ST_EXEC);
endmodule

// file: src/opdec_regs.svh
// constants for the opcode decode and timing slice
// assumes inclusion by bare name from src/
`ifndef OPDEC_REGS_SVH
`define OPDEC_REGS_SVH
// opcode patterns
`define OPC_EOL      8'h8d
`define OPC_FPL_DS   8'hc5
`define OPC_FPL_ES   8'hc4
`define OPC_F2A      8'h9f
`define OPC_A2F      8'h9e
`define OPC_FSAVE    8'h9c
`define OPC_FREST    8'h9d
`define OPC_ADD_RM   6'h00
`define OPC_ADC_RM   6'h04
`define OPC_SUB_RM   6'h0a
`define OPC_IMM_GRP  6'h20
`define OPC_ADD_ACC  7'h02
`define OPC_ADC_ACC  7'h0a
`define OPC_INCDEC_RM 7'h7f
`define OPC_INC_REG  5'h08
`define SUB_ADD      3'h0
`define SUB_ADC      3'h2
`define SUB_INC      3'h0
`define MOD_REG      2'h3
// clock counts
`define CLK_EOL        5'd3
`define CLK_FPL_REAL   5'd7
`define CLK_FPL_PROT   5'd21
`define CLK_FLAGXFER   5'd2
`define CLK_FSAVE      5'd3
`define CLK_FREST      5'd5
`define CLK_ALU_REG    5'd2
`define CLK_ALU_MEM    5'd7
`define CLK_IMM_REG    5'd3
`define CLK_ACC_IMM    5'd3
`define CLK_INC_REG    5'd2
`endif

// file: src/opdec_pkg.sv
// types for the opcode decode and timing slice
// assumes nothing of its surroundings
package opdec_pkg;
  typedef enum logic [4:0] {
    OP_NONE, OP_EOL, OP_FPL_DS, OP_FPL_ES, OP_F2A, OP_A2F, OP_FSAVE, OP_FREST,
    OP_ADD, OP_ADC, OP_INC, OP_SUB
  } op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MODRM = 2'b01,
    ST_EXEC = 2'b11
  } state_t;
endpackage

// file: src/cycle_timer.sv
// down counter that holds an instruction's execution clock count
// assumes load and count come from the same clock domain
module cycle_timer #(
  parameter int W = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic done
);
  logic [W-1:0] cnt_q;
  wire logic [W-1:0] cnt_d = load ? count : (cnt_q != '0 ? cnt_q - 1'b1 : cnt_q);
  assign done = (cnt_q == {{(W-1){1'b0}}, 1'b1});
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end
endmodule

// file: dv/opdec_top_properties.sv
// concurrent checks on the decode and timing ports
// assumes a bind onto opdec_top from the bench
module opdec_checker (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // observed ports
  input wire logic [7:0] BYTE_DATA,
  input wire logic PROT_MODE,
  input wire logic DEC_VALID,
  input wire opdec_pkg::op_t DEC_OP,
  input wire logic [2:0] DEC_REG,
  input wire logic [2:0] DEC_RM,
  input wire logic [1:0] DEC_MOD,
  input wire logic [4:0] DEC_CLOCKS,
  input wire logic DEC_IMM,
  input wire logic EXEC_DONE
);
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);
  a_offset_load: assert property (DEC_VALID && DEC_OP == opdec_pkg::OP_EOL
    |-> DEC_CLOCKS == 5'd3) else $error("offset load count");
  a_far_ptr: assert property (DEC_VALID && DEC_MOD != 2'h3 && DEC_OP inside
    {opdec_pkg::OP_FPL_DS, opdec_pkg::OP_FPL_ES}
    |-> DEC_CLOCKS == ($past(PROT_MODE) ? 5'd21 : 5'd7)) else $error("far pointer count");
  a_long_exec: assert property (DEC_VALID && DEC_CLOCKS == 5'd7
    |-> ##6 EXEC_DONE) else $error("seven clock end late");
  a_flag_copy: assert property (DEC_VALID && DEC_OP inside
    {opdec_pkg::OP_F2A, opdec_pkg::OP_A2F} |-> DEC_CLOCKS == 5'd2 ##1 EXEC_DONE)
    else $error("flag copy timing");
  a_flag_save: assert property (DEC_VALID && DEC_OP == opdec_pkg::OP_FSAVE
    |-> DEC_CLOCKS == 5'd3 ##2 EXEC_DONE) else $error("flag save timing");
  a_restore_time: assert property (DEC_VALID && DEC_OP == opdec_pkg::OP_FREST
    |-> DEC_CLOCKS == 5'd5 ##1 !EXEC_DONE [*3] ##1 EXEC_DONE) else $error("restore timing");
  a_acc_carry: assert property (DEC_VALID && DEC_RM == 3'h0 && DEC_MOD == 2'h0
    && $past(BYTE_DATA) inside {8'h14, 8'h15}
    |-> DEC_OP == opdec_pkg::OP_ADC && DEC_CLOCKS == 5'd3) else $error("acc carry form");
  a_inc_reg: assert property (DEC_VALID && DEC_OP == opdec_pkg::OP_INC && DEC_MOD == 2'h0
    && $past(BYTE_DATA) inside {[8'h40:8'h47]}
    |-> DEC_CLOCKS == 5'd2 && DEC_REG == $past(BYTE_DATA[2:0])) else $error("inc register");
  // immediate forms with a foreign sub-code keep the subtract class but are illegal
  a_sub_clocks: assert property (DEC_VALID && DEC_OP == opdec_pkg::OP_SUB && !DEC_IMM
    |-> DEC_CLOCKS == (DEC_MOD == 2'h3 ? 5'd2 : 5'd7)) else $error("subtract count");
endmodule

// file: dv/cpu_opcode_decode_timing_slice_bench.sv
// self-checking bench for the opcode decode and timing slice
// assumes opdec_top and opdec_checker are compiled before it
module cpu_opcode_decode_timing_slice_bench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic [7:0] b0;
    logic [7:0] b1;
    bit two;
    bit pm;
    opdec_pkg::op_t op;
    logic [4:0] ec;
    logic [2:0] dw;
  } row_t;
  logic CLK_SYS = 1'b0;
  logic RSTN = 1'b0;
  logic BYTE_VALID = 1'b0;
  logic [7:0] BYTE_DATA = 8'h00;
  logic PROT_MODE = 1'b0;
  logic BYTE_READY, DEC_VALID, DEC_WORD, DEC_TO_REG, DEC_IMM, DEC_ILLEGAL, EXEC_DONE;
  logic [2:0] DEC_REG, DEC_RM;
  logic [1:0] DEC_MOD;
  logic [4:0] DEC_CLOCKS;
  opdec_pkg::op_t DEC_OP;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  // opcode, modrm, two bytes, protected, class, clocks, {imm,d,w}
  row_t rows [18] = '{
    '{8'h8d, 8'h46, 1, 1, opdec_pkg::OP_EOL, 5'd3, 3'b001},
    '{8'hc5, 8'h06, 1, 0, opdec_pkg::OP_FPL_DS, 5'd7, 3'b001},
    '{8'hc5, 8'h86, 1, 1, opdec_pkg::OP_FPL_DS, 5'd21, 3'b001},
    '{8'hc4, 8'h06, 1, 1, opdec_pkg::OP_FPL_ES, 5'd21, 3'b000},
    '{8'h9f, 8'h00, 0, 1, opdec_pkg::OP_F2A, 5'd2, 3'b001},
    '{8'h9e, 8'h00, 0, 0, opdec_pkg::OP_A2F, 5'd2, 3'b000},
    '{8'h9c, 8'h00, 0, 0, opdec_pkg::OP_FSAVE, 5'd3, 3'b000},
    '{8'h9d, 8'h00, 0, 1, opdec_pkg::OP_FREST, 5'd5, 3'b001},
    '{8'h13, 8'hc1, 1, 0, opdec_pkg::OP_ADC, 5'd2, 3'b011},
    '{8'h83, 8'hd1, 1, 0, opdec_pkg::OP_ADC, 5'd3, 3'b101},
    '{8'h15, 8'h00, 0, 0, opdec_pkg::OP_ADC, 5'd3, 3'b101},
    '{8'h47, 8'h00, 0, 0, opdec_pkg::OP_INC, 5'd2, 3'b001},
    '{8'h29, 8'hd8, 1, 0, opdec_pkg::OP_SUB, 5'd2, 3'b001},
    '{8'h2a, 8'h06, 1, 0, opdec_pkg::OP_SUB, 5'd7, 3'b010},
    '{8'h01, 8'hd8, 1, 0, opdec_pkg::OP_ADD, 5'd2, 3'b001},
    '{8'h04, 8'h00, 0, 0, opdec_pkg::OP_ADD, 5'd3, 3'b100},
    '{8'h81, 8'h06, 1, 0, opdec_pkg::OP_ADD, 5'd7, 3'b101},
    '{8'hfe, 8'hc0, 1, 0, opdec_pkg::OP_INC, 5'd2, 3'b000}
  };
  opdec_top u_opdec_top (
    .CLK_SYS, .RSTN, .BYTE_VALID, .BYTE_DATA, .BYTE_READY, .PROT_MODE, .DEC_VALID, .DEC_OP,
    .DEC_REG, .DEC_RM, .DEC_MOD, .DEC_WORD, .DEC_TO_REG, .DEC_IMM, .DEC_ILLEGAL, .DEC_CLOCKS,
    .EXEC_DONE
  );
  always #2.5 CLK_SYS = ~CLK_SYS;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (e !== s)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one instruction: bytes in, then decode fields and execution length
  task automatic xfer(input row_t r, input bit ill);
    int n;
    @(posedge CLK_SYS);
    PROT_MODE <= r.pm;
    BYTE_VALID <= 1'b1;
    BYTE_DATA <= r.b0;
    @(posedge CLK_SYS);
    if (r.two)
    begin
      BYTE_DATA <= r.b1;
      @(posedge CLK_SYS);
    end
    BYTE_VALID <= 1'b0;
    BYTE_DATA <= ~r.b1;
    #1;
    chk("valid_ready", 8'h02, {6'h0, DEC_VALID, BYTE_READY});
    chk("illegal", {7'h0, ill}, {7'h0, DEC_ILLEGAL});
    if (!ill)
    begin
      chk("op", 8'(r.op), 8'(DEC_OP));
      chk("clocks", {3'h0, r.ec}, {3'h0, DEC_CLOCKS});
      chk("dir_size", {5'h0, r.dw}, {5'h0, DEC_IMM, DEC_TO_REG, DEC_WORD});
      // modrm fields pass through; one-byte forms report only the increment register
      chk("fields", r.two ? r.b1 : {2'h0, (r.b0[7:3] == 5'h08) ? r.b0[2:0] : 3'h0, 3'h0},
        {DEC_MOD, DEC_REG, DEC_RM});
    end
    n = 1;
    while (EXEC_DONE !== 1'b1 && n < 30)
    begin
      @(posedge CLK_SYS);
      #1;
      n++;
    end
    if (!ill)
      chk("exec_len", {3'h0, r.ec}, 8'(n));
  endtask
  always @(posedge CLK_SYS)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (16) @(posedge CLK_SYS);
    chk("reset_ready", 8'h01, {7'h0, BYTE_READY});
    $display("reset test done");
    RSTN <= 1'b1;
    foreach (rows[i])
      xfer(rows[i], 1'b0);
    $display("decode table done");
    xfer(row_t'{8'hc5, 8'hc0, 1, 0, opdec_pkg::OP_NONE, 5'd0, 3'b000}, 1'b1);
    xfer(row_t'{8'h83, 8'hd9, 1, 0, opdec_pkg::OP_NONE, 5'd0, 3'b000}, 1'b1);
    xfer(row_t'{8'hfe, 8'hc8, 1, 0, opdec_pkg::OP_NONE, 5'd0, 3'b000}, 1'b1);
    xfer(row_t'{8'h90, 8'h00, 0, 0, opdec_pkg::OP_NONE, 5'd0, 3'b000}, 1'b1);
    $display("illegal forms done");
    // reset lands in mid execution, then the block must start clean
    @(posedge CLK_SYS);
    BYTE_VALID <= 1'b1;
    BYTE_DATA <= 8'h9d;
    @(posedge CLK_SYS);
    BYTE_VALID <= 1'b0;
    @(posedge CLK_SYS);
    RSTN <= 1'b0;
    #1;
    chk("rst_state", 8'h01, {5'h0, EXEC_DONE, DEC_VALID, BYTE_READY});
    @(posedge CLK_SYS);
    RSTN <= 1'b1;
    xfer(rows[7], 1'b0);
    $display("mid-run reset done");
    tally_and_finish();
  end
endmodule
bind opdec_top opdec_checker u_opdec_checker (.CLK_SYS, .RSTN, .BYTE_DATA, .PROT_MODE,
  .DEC_VALID, .DEC_OP, .DEC_REG, .DEC_RM, .DEC_MOD, .DEC_CLOCKS, .DEC_IMM, .EXEC_DONE);
